// ### hdl/dots_dev.sv
// memory device end: termination control and bank command acceptance
//Contract
//- controller clears third extended register on init
//- termination switches on every data-side pin
//- termination obeys odt, off in self refresh
//- controller enables termination via rtt field
//- rtt field picks 75, 150, 50 ohm
//- strobe, read strobe, mask termination per bits
//- termination turns on two cycles after odt
//- termination turns off 2.5 cycles after odt; the device turns it off after 3
//- power-down window uses slower termination timing
//- controller spaces odt change before power-down
//- controller waits after power-down exit; its exit gap only holds back power-down re-entry, requests are taken at once
//- slow-exit bit clear keeps fixed timings
//- activate decode opens the addressed bank
//- row address width follows organisation
//- column command accepted cycle after activate
//- additive latency zero to six delays issue
//- controller activates before access, precharges before reactivate
//- controller spaces activates by row timings
//- column command decode, we selects read/write
//- burst four column spacing two clocks
//- burst eight column spacing four clocks
//- a10 disables complement strobe, a11 enables read strobe
`timescale 1ns/1ps
module dots_dev #(
	parameter bit X16 = 1'b0
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	dots_if.dev bus,
	input wire logic self_refresh_in,
	output logic [1:0] rtt_sel_out,
	output logic term_dq_out,
	output logic term_dqs_n_out,
	output logic term_rdqs_out,
	output logic term_rdqs_n_out,
	output logic term_dm_out,
	output logic rd_issue_out,
	output logic wr_issue_out,
	output logic [2:0] issue_bank_out,
	output logic [dots_pkg::BANKS-1:0] bank_open_out,
	output logic [dots_pkg::ROW_W-1:0] act_row_out,
	output logic spacing_err_out
);
	import dots_pkg::*;
	logic [3:0] cmd;
	logic [13:0] emr1_q;
	logic [13:0] mr_q;
	logic [6:0] odt_tap;
	logic odt_on_d;
	logic odt_off_d;
	logic term_d;
	logic term_q;
	logic half_q;
	logic cke_q;
	logic [3:0] pd_win_q;
	logic [6:0] rd_tap;
	logic [6:0] wr_tap;
	logic [2:0] ba_tap [0:AL_MAX];
	logic [2:0] al;
	logic [2:0] ccd_cnt_q;
	logic pd_slow;
	logic al_rd;
	logic al_wr;
	logic [2:0] al_ba;
	dots_pwr_t pwr_q;
	assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
	assign al = emr1_q[EMR_AL_LO+2:EMR_AL_LO];
	// mode registers captured on register set commands
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			emr1_q <= '0;
			mr_q <= '0;
		end else if (ce_in && cmd == CMD_MRS) begin
			if (bus.ba == BA_EMR1) begin
				emr1_q <= bus.addr;
			end else if (bus.ba == BA_MR) begin
				mr_q <= bus.addr;
			end
		end
	end
	// power state from clock enable and self refresh
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pwr_q <= DOTS_ACTIVE;
			cke_q <= 1'b1;
			pd_win_q <= '0;
		end else if (ce_in) begin
			cke_q <= bus.cke;
			case (1'b1)
				self_refresh_in: pwr_q <= DOTS_SREF;
				!bus.cke: pwr_q <= DOTS_PDOWN;
				default: pwr_q <= DOTS_ACTIVE;
			endcase
			// window around entry and exit where slow timing applies
			if (cke_q != bus.cke) begin
				pd_win_q <= bus.cke ? 4'(AXPD_CYC) : 4'(ANPD_CYC);
			end else if (pd_win_q != '0) begin
				pd_win_q <= pd_win_q - 4'h1;
			end
		end
	end
	// odt sampled each rising edge and delayed
	dots_delay #(.DEPTH(7)) u_odt (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.en_in(ce_in),
		.d_in(bus.odt),
		.tap_out(odt_tap)
	);
	// slow timing in power-down and in its entry and exit window, only when bit is set
	assign pd_slow = mr_q[MR_PD_SLOW] && (pwr_q == DOTS_PDOWN || pd_win_q != '0);
	assign odt_on_d = pd_slow ? odt_tap[ODT_PD_ON_CYC-1] : odt_tap[ODT_ON_HALF/2-1];
	assign odt_off_d = pd_slow ? odt_tap[ODT_PD_OFF_CYC-1] : odt_tap[ODT_OFF_HALF/2-1];
	// turn on at two cycles; turn off one whole cycle after the two-cycle tap
	always_comb begin
		term_d = term_q;
		if (odt_on_d && !term_q) begin
			term_d = 1'b1;
		end else if (!odt_off_d && term_q && half_q) begin
			term_d = 1'b0;
		end
		if (pwr_q == DOTS_SREF || self_refresh_in) begin
			term_d = 1'b0;
		end
	end
	// termination state; turn-off waits an extra cycle to stand for the half
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			term_q <= 1'b0;
			half_q <= 1'b0;
		end else if (ce_in) begin
			half_q <= term_q && !odt_off_d && !half_q;
			term_q <= term_d;
		end
	end
	// per-pin termination enables
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rtt_sel_out <= RTT_OFF;
			term_dq_out <= 1'b0;
			term_dqs_n_out <= 1'b0;
			term_rdqs_out <= 1'b0;
			term_rdqs_n_out <= 1'b0;
			term_dm_out <= 1'b0;
		end else if (ce_in) begin
			rtt_sel_out <= {emr1_q[EMR_RTT_HI], emr1_q[EMR_RTT_LO]};
			term_dq_out <= term_d && ({emr1_q[EMR_RTT_HI], emr1_q[EMR_RTT_LO]} != RTT_OFF);
			term_dqs_n_out <= term_d && !emr1_q[EMR_DQS_DIS] && (emr1_q[EMR_RTT_HI] | emr1_q[EMR_RTT_LO]);
			term_rdqs_out <= !X16 && term_d && emr1_q[EMR_RDQS_EN] && (emr1_q[EMR_RTT_HI] | emr1_q[EMR_RTT_LO]);
			term_rdqs_n_out <= !X16 && term_d && emr1_q[EMR_RDQS_EN] && !emr1_q[EMR_DQS_DIS]
				&& (emr1_q[EMR_RTT_HI] | emr1_q[EMR_RTT_LO]);
			term_dm_out <= term_d && (X16 || !emr1_q[EMR_RDQS_EN]) && (emr1_q[EMR_RTT_HI] | emr1_q[EMR_RTT_LO]);
		end
	end
	// column commands delayed by additive latency
	dots_delay #(.DEPTH(AL_MAX+1)) u_rd (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.en_in(ce_in),
		.d_in(cmd == CMD_RD),
		.tap_out(rd_tap)
	);
	dots_delay #(.DEPTH(AL_MAX+1)) u_wr (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.en_in(ce_in),
		.d_in(cmd == CMD_WR),
		.tap_out(wr_tap)
	);
	// bank addresses kept alongside the delayed commands
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i <= AL_MAX; i++) begin
				ba_tap[i] <= '0;
			end
		end else if (ce_in) begin
			ba_tap[0] <= bus.ba;
			for (int i = 1; i <= AL_MAX; i++) begin
				ba_tap[i] <= ba_tap[i-1];
			end
		end
	end
	// select issue point: zero latency uses the live command
	always_comb begin
		al_rd = (cmd == CMD_RD);
		al_wr = (cmd == CMD_WR);
		al_ba = bus.ba;
		if (al != 3'h0 && al <= 3'(AL_MAX)) begin
			al_rd = rd_tap[al-3'h1];
			al_wr = wr_tap[al-3'h1];
			al_ba = ba_tap[al-3'h1];
		end
	end
	// internal issue pulses and bank state
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_issue_out <= 1'b0;
			wr_issue_out <= 1'b0;
			issue_bank_out <= '0;
			bank_open_out <= '0;
			act_row_out <= '0;
		end else if (ce_in) begin
			rd_issue_out <= al_rd;
			wr_issue_out <= al_wr;
			issue_bank_out <= al_ba;
			if (cmd == CMD_ACT) begin
				bank_open_out[bus.ba] <= 1'b1;
				act_row_out <= X16 ? {1'b0, bus.addr[12:0]} : bus.addr;
			end else if (cmd == CMD_PRE) begin
				if (bus.addr[10]) begin
					bank_open_out <= '0;
				end else begin
					bank_open_out[bus.ba] <= 1'b0;
				end
			end
		end
	end
	// column spacing check, burst length from mode register bits 2:0
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ccd_cnt_q <= '0;
			spacing_err_out <= 1'b0;
		end else if (ce_in) begin
			if (cmd == CMD_RD || cmd == CMD_WR) begin
				spacing_err_out <= ccd_cnt_q != '0;
				ccd_cnt_q <= (mr_q[2:0] == 3'h3) ? 3'(CCD_BL8 - 1) : 3'(CCD_BL4 - 1);
			end else begin
				spacing_err_out <= 1'b0;
				if (ccd_cnt_q != '0) begin
					ccd_cnt_q <= ccd_cnt_q - 3'h1;
				end
			end
		end
	end
endmodule : dots_dev

// ### hdl/dots_pkg.sv
// package of shared constants and types for the termination and bank command logic
package dots_pkg;
	// command encoding as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_NOP = 4'h7;
	// extended mode register one field positions, plus the mode register slow-exit bit
	localparam int EMR_RTT_LO = 2;
	localparam int EMR_AL_LO = 3;
	localparam int EMR_RTT_HI = 6;
	localparam int EMR_DQS_DIS = 10;
	localparam int EMR_RDQS_EN = 11;
	localparam int MR_PD_SLOW = 12;
	// termination value selection
	localparam logic [1:0] RTT_OFF = 2'h0;
	localparam logic [1:0] RTT_75 = 2'h1;
	localparam logic [1:0] RTT_150 = 2'h2;
	localparam logic [1:0] RTT_50 = 2'h3;
	// termination delays in half clock cycles
	localparam int ODT_ON_HALF = 4;
	localparam int ODT_OFF_HALF = 5;
	// slower power-down timings, in cycles at the device clock
	localparam int ODT_PD_ON_CYC = 3;
	localparam int ODT_PD_OFF_CYC = 4;
	// power-down window latencies
	localparam int ANPD_CYC = 3;
	localparam int AXPD_CYC = 8;
	localparam int AL_MAX = 6;
	localparam int CCD_BL4 = 2;
	localparam int CCD_BL8 = 4;
	localparam logic [2:0] BA_EMR1 = 3'h1;
	localparam logic [2:0] BA_EMR3 = 3'h3;
	localparam logic [2:0] BA_MR = 3'h0;
	localparam int ROW_W = 14;
	localparam int BANKS = 8;
	typedef enum logic [1:0] {DOTS_ACTIVE, DOTS_PDOWN, DOTS_SREF} dots_pwr_t;
endpackage : dots_pkg

// ### hdl/dots_if.sv
// interface joining the controller end to the memory device end
`timescale 1ns/1ps
interface dots_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [2:0] ba;
	logic [13:0] addr;
	logic odt;
	logic cke;
	modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, addr, odt, cke);
	modport dev (input cs_n, ras_n, cas_n, we_n, ba, addr, odt, cke);
endinterface : dots_if

// ### hdl/dots_delay.sv
// delay line of one bit, used for additive latency and termination timing
`timescale 1ns/1ps
module dots_delay #(
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic en_in,
	input wire logic d_in,
	output logic [DEPTH-1:0] tap_out
);
	// shift register, tap k holds the input of k+1 cycles ago
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tap_out <= '0;
		end else if (en_in) begin
			tap_out <= {tap_out[DEPTH-2:0], d_in};
		end
	end
endmodule : dots_delay

// ### hdl/dots_ctrl.sv
// controller end: drives commands and odt, keeps its own spacing
`timescale 1ns/1ps
module dots_ctrl (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	dots_if.ctrl bus,
	input wire logic req_valid_in,
	input wire logic [3:0] req_cmd_in,
	input wire logic [2:0] req_ba_in,
	input wire logic [13:0] req_addr_in,
	input wire logic odt_in,
	input wire logic cke_in,
	output logic req_ready_out
);
	import dots_pkg::*;
	logic [2:0] gap_q;
	logic [2:0] gap_d;
	logic [3:0] pd_gap_q;
	logic odt_q;
	logic legal;
	logic take;
	logic cke_d;
	logic [BANKS-1:0] open_q;
	// a request is taken when valid meets the ready raised on the edge before
	assign take = req_valid_in && req_ready_out;
	// bank state decides whether a taken request reaches the pins
	always_comb begin
		case (req_cmd_in)
			CMD_ACT: legal = !open_q[req_ba_in];
			CMD_RD, CMD_WR: legal = open_q[req_ba_in];
			default: legal = 1'b1;
		endcase
	end
	// spacing counter, reloaded by each read, write or activate that reaches the pins
	always_comb begin
		gap_d = (gap_q != '0) ? gap_q - 3'h1 : 3'h0;
		if (take && legal) begin
			if (req_cmd_in == CMD_RD || req_cmd_in == CMD_WR) begin
				gap_d = 3'(CCD_BL8 - 1);
			end else if (req_cmd_in == CMD_ACT) begin
				gap_d = 3'h1;
			end
		end
	end
	// power-down entry waits out the odt settle gap; exit is never held back
	always_comb begin
		cke_d = bus.cke;
		if (cke_in || (pd_gap_q == '0 && odt_in == odt_q)) begin
			cke_d = cke_in;
		end
	end
	// drive pins; ready tells whether the next edge may take a request
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_NOP;
			bus.ba <= '0;
			bus.addr <= '0;
			bus.odt <= 1'b0;
			bus.cke <= 1'b1;
			odt_q <= 1'b0;
			gap_q <= '0;
			pd_gap_q <= '0;
			open_q <= '0;
			req_ready_out <= 1'b0;
		end else if (ce_in) begin
			req_ready_out <= (gap_d == '0) && cke_d;
			{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_NOP;
			gap_q <= gap_d;
			if (take && legal) begin
				{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= req_cmd_in;
				bus.ba <= req_ba_in;
				bus.addr <= req_addr_in;
				if (req_cmd_in == CMD_ACT) begin
					open_q[req_ba_in] <= 1'b1;
				end else if (req_cmd_in == CMD_PRE) begin
					open_q[req_ba_in] <= 1'b0;
				end
			end
			bus.odt <= odt_in;
			odt_q <= odt_in;
			bus.cke <= cke_d;
			// settle gap after an odt change or a power-down exit
			if (odt_in != odt_q) begin
				pd_gap_q <= 4'(ANPD_CYC);
			end else if (cke_d && !bus.cke) begin
				pd_gap_q <= 4'(AXPD_CYC);
			end else if (pd_gap_q != '0) begin
				pd_gap_q <= pd_gap_q - 4'h1;
			end
		end
	end
endmodule : dots_ctrl

// ### test/dots_properties.sv
// concurrent checks on the command, address and termination lines between the two ends
`timescale 1ns/1ps
module dots_properties (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [13:0] addr,
	input wire logic odt,
	input wire logic cke
);
	import dots_pkg::*;
	logic [7:0] open_q;
	logic rtt_en_q;
	logic odt_q;
	logic [2:0] still_q;
	wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	wire logic act_w = cmd == CMD_ACT;
	wire logic col_w = !cs_n && ras_n && !cas_n;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	sequence col_s;
		col_w;
	endsequence
	sequence act_s;
		act_w;
	endsequence
	// banks opened by activate and closed by precharge
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			open_q <= 8'h00;
		end else if (act_w) begin
			open_q[ba] <= 1'b1;
		end else if (cmd == CMD_PRE) begin
			open_q[ba] <= 1'b0;
		end
	end
	// termination enabled once the value field is written non-zero
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rtt_en_q <= 1'b0;
		end else if (cmd == CMD_MRS && ba == BA_EMR1) begin
			rtt_en_q <= addr[EMR_RTT_HI] | addr[EMR_RTT_LO];
		end
	end
	// cycles for which odt has held still, saturating
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			odt_q <= 1'b0;
			still_q <= 3'h0;
		end else begin
			odt_q <= odt;
			still_q <= (odt != odt_q) ? 3'h0 : still_q + ((still_q == 3'h7) ? 3'h0 : 3'h1);
		end
	end
	col_gap_long_a: assert property (col_s |=> (!col_w)[*3])
		else $error("column commands closer than four clocks");
	col_gap_short_a: assert property (col_s |=> !col_w)
		else $error("column commands on adjacent clocks");
	act_gap_a: assert property (act_s |=> !act_w)
		else $error("activates on adjacent clocks");
	col_open_bank_a: assert property (col_s |-> open_q[ba])
		else $error("column command to a closed bank");
	act_closed_bank_a: assert property (act_s |-> !open_q[ba])
		else $error("activate to an open bank");
	emr3_zero_a: assert property (cmd == CMD_MRS && ba == BA_EMR3 |-> addr == 14'h0000)
		else $error("third extended register written non-zero");
	odt_enabled_a: assert property (odt |-> rtt_en_q)
		else $error("odt raised with termination disabled");
	pd_entry_gap_a: assert property ($fell(cke) |-> still_q >= 3'h3)
		else $error("power-down entered too soon after odt change");
endmodule : dots_properties

// ### test/dots_tb.sv
// testbench joining controller and device ends, checking termination and bank commands
`timescale 1ns/1ps
module dots_tb;
	import dots_pkg::*;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic req_valid = 1'b0;
	logic [3:0] req_cmd = CMD_NOP;
	logic [2:0] req_ba = 3'h0;
	logic [13:0] req_addr = 14'h0000;
	logic odt = 1'b0;
	logic cke = 1'b1;
	logic sref = 1'b0;
	logic ready;
	logic [1:0] rtt;
	logic dq, dqs_n, rdqs, rdqs_n, dm, rd, wr, err;
	logic [2:0] ibank;
	logic [2:0] ibank_at;
	logic [7:0] bopen;
	logic [13:0] row;
	logic [31:0] obs;
	int errors = 0;
	int checks = 0;
	dots_if bus_if();
	dots_ctrl dots_ctrl_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(1'b1), .bus(bus_if.ctrl),
		.req_valid_in(req_valid), .req_cmd_in(req_cmd), .req_ba_in(req_ba), .req_addr_in(req_addr),
		.odt_in(odt), .cke_in(cke), .req_ready_out(ready));
	dots_dev #(.X16(1'b0)) dots_dev_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(1'b1),
		.bus(bus_if.dev), .self_refresh_in(sref), .rtt_sel_out(rtt), .term_dq_out(dq), .term_dqs_n_out(dqs_n),
		.term_rdqs_out(rdqs), .term_rdqs_n_out(rdqs_n), .term_dm_out(dm), .rd_issue_out(rd), .wr_issue_out(wr),
		.issue_bank_out(ibank), .bank_open_out(bopen), .act_row_out(row), .spacing_err_out(err));
	dots_properties dots_properties_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cs_n(bus_if.cs_n),
		.ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .ba(bus_if.ba), .addr(bus_if.addr),
		.odt(bus_if.odt), .cke(bus_if.cke));
	// observed device outputs packed for masked comparison
	assign obs = {row, bopen, rtt, dm, rdqs_n, rdqs, dqs_n, dq, wr, rd, err};
	// free-running clock
	always #12.5 clk_sys_in = ~clk_sys_in;
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// present a request and hold it until the taking edge
	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
		int i;
		req_cmd <= c;
		req_ba <= b;
		req_addr <= a;
		req_valid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge clk_sys_in);
			if (ready === 1'b1) break;
		end
		if (i == 50) begin
			errors++;
			stop_test();
		end
		@(posedge clk_sys_in);
	endtask : issue
	task automatic idle();
		req_valid <= 1'b0;
		@(posedge clk_sys_in);
	endtask : idle
	// edges until obs bit reaches lvl, 20 when it never does
	task automatic lat(input int idx, input logic lvl, input int exp);
		int k;
		req_valid <= 1'b0;
		for (k = 1; k < 20; k++) begin
			@(posedge clk_sys_in);
			@(negedge clk_sys_in);
			ibank_at = ibank;
			if (obs[idx] === lvl) break;
		end
		check(32'(k), 32'(exp), "latency");
		@(posedge clk_sys_in);
	endtask : lat
	task automatic poll(input logic [31:0] mask, input logic [31:0] exp, input string what);
		for (int k = 0; k < 20; k++) begin
			@(negedge clk_sys_in);
			if ((obs & mask) === exp) break;
		end
		check(obs & mask, exp, what);
		@(posedge clk_sys_in);
	endtask : poll
	task automatic emr(input logic [2:0] al, input logic a10, input logic a11, input logic [1:0] r);
		issue(CMD_MRS, BA_EMR1, {2'h0, a11, a10, 3'h0, r[1], al, r[0], 2'h0});
		idle();
	endtask : emr
	// main sequence
	initial begin
		repeat (20) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(posedge clk_sys_in);
		@(negedge clk_sys_in);
		check(obs, 32'h0, "reset state");
		@(posedge clk_sys_in);
		issue(CMD_MRS, BA_EMR3, 14'h0000);
		idle();
		for (int v = 1; v < 4; v++) begin
			emr(3'h0, 1'b0, 1'b1, 2'(v));
			poll(32'h300, 32'(v) << 8, "rtt");
		end
		for (int m = 0; m < 4; m++) begin
			emr(3'h0, m[0], m[1], RTT_150);
			odt <= 1'b1;
			@(posedge clk_sys_in);
			lat(3, 1'b1, ODT_ON_HALF / 2 + 1);
			check(32'(obs[7:3]), 32'({!m[1], !m[0] & m[1], m[1], !m[0], 1'b1}), "terms");
			odt <= 1'b0;
			@(posedge clk_sys_in);
			lat(3, 1'b0, (ODT_OFF_HALF + 1) / 2 + 1);
		end
		sref <= 1'b1;
		cke <= 1'b0;
		@(posedge clk_sys_in);
		odt <= 1'b1;
		lat(3, 1'b1, 20);
		odt <= 1'b0;
		sref <= 1'b0;
		cke <= 1'b1;
		repeat (AXPD_CYC) @(posedge clk_sys_in);
		// issue pulse one pin stage plus the additive latency after the take
		for (int a = 0; a <= AL_MAX; a++) begin
			emr(3'(a), 1'b0, 1'b0, RTT_75);
			issue(CMD_ACT, 3'(a), 14'h2A5C ^ 14'(a));
			issue(a[0] ? CMD_WR : CMD_RD, 3'(a), 14'h0000);
			lat(a[0] ? 2 : 1, 1'b1, a + 1);
			check(32'(ibank_at), 32'(a), "issue bank");
			poll(32'hFFFFFC00, {14'h2A5C ^ 14'(a), 8'(1 << a), 10'h000}, "row");
			issue(CMD_PRE, 3'(a), 14'h0000);
			idle();
		end
		poll(32'h3FC00, 32'h0, "banks");
		// slow power-down exit selected, burst of eight; odt moved inside power-down
		issue(CMD_MRS, BA_MR, 14'h1003);
		idle();
		cke <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		odt <= 1'b1;
		@(posedge clk_sys_in);
		lat(3, 1'b1, ODT_PD_ON_CYC + 1);
		odt <= 1'b0;
		@(posedge clk_sys_in);
		lat(3, 1'b0, ODT_PD_OFF_CYC + 2);
		cke <= 1'b1;
		repeat (AXPD_CYC + 2) @(posedge clk_sys_in);
		issue(CMD_ACT, 3'h7, 14'h0001);
		issue(CMD_RD, 3'h7, 14'h0000);
		issue(CMD_WR, 3'h7, 14'h0000);
		lat(0, 1'b1, 20);
		stop_test();
	end
endmodule : dots_tb
